/* File: ddr2_command_timing_enforcer.v */
`timescale 1ns/1ps
`include "ddr2_timing_regs.vh"

module ddr2_command_timing_enforcer #(
  parameter NBANKS = 8,
  parameter BANK_W = 3
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // command request from scheduler
  input wire cmd_valid,
  input wire [2:0] cmd_type,
  input wire [BANK_W-1:0] cmd_bank,
  output wire cmd_ready,
  // final write data beat
  input wire write_data_last,
  // memory side status
  output reg cke,
  output reg init_start,
  output wire self_refresh_active
);

  // register storage
  reg [31:0] timing_pri_q;
  reg [31:0] timing_sec_q;
  reg [31:0] bank_cfg_q;
  reg [31:0] ref_ctrl_q;

  // apb decode
  wire setup_phase = psel & ~penable;
  wire access_wr = psel & penable & pwrite;
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_bank = (paddr == `OFS_BANK_CONFIG);
  wire hit_ref = (paddr == `OFS_REFRESH_CTRL);
  wire hit_pri = (paddr == `OFS_TIMING_PRI);
  wire hit_sec = (paddr == `OFS_TIMING_SEC);
  wire mapped = hit_status | hit_bank | hit_ref | hit_pri | hit_sec;
  wire unlocked = bank_cfg_q[`BIT_UNLOCK];
  wire wr_pri = access_wr & hit_pri & unlocked; // see [RULE12]
  wire wr_sec = access_wr & hit_sec & unlocked; // see [RULE12]
  wire [31:0] pri_new = pwdata & `PRI_MASK;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // global timing counters
  reg [6:0] rfc_q;
  reg [4:0] rc_q;
  reg [2:0] rrd_q;
  reg [1:0] wtr_q;
  reg [2:0] wr_q;
  reg [2:0] rtp_q;
  reg [6:0] xsnr_q;
  reg [7:0] xsrd_q;
  reg [4:0] cke_cnt_q;

  // per-bank zero flags
  wire [NBANKS-1:0] rcd_zero;
  wire [NBANKS-1:0] ras_zero;
  wire [NBANKS-1:0] rp_zero;

  // command acceptance
  wire issue = cmd_valid & cmd_ready;
  wire is_act = issue & (cmd_type == `CMD_ACTIVATE);
  wire is_pre = issue & (cmd_type == `CMD_PRECHARGE);
  wire is_rd = issue & (cmd_type == `CMD_READ);
  wire is_wr = issue & (cmd_type == `CMD_WRITE);
  wire is_rfc = issue & ((cmd_type == `CMD_REFRESH) | (cmd_type == `CMD_MODE_LOAD));
  wire sr_req = ref_ctrl_q[`BIT_SELF_REF];
  wire run = cke & ~sr_req;
  reg ready_c;

  assign self_refresh_active = ~cke;
  assign cmd_ready = ready_c;

  // ready decision per command kind
  always @* begin
    ready_c = 1'b0;
    case (cmd_type)
      `CMD_REFRESH: begin
        ready_c = run & (rfc_q == 7'h00) & (&rp_zero) & (xsnr_q == 7'h00); // see [RULE1] see [RULE2] see [RULE13]
      end
      `CMD_MODE_LOAD: begin
        ready_c = run & (rfc_q == 7'h00) & (&rp_zero) & (xsnr_q == 7'h00); // see [RULE13]
      end
      `CMD_ACTIVATE: begin
        ready_c = run & (rfc_q == 7'h00) & rp_zero[cmd_bank] & (rc_q == 5'h00) & (rrd_q == 3'h0)
                  & (xsnr_q == 7'h00); // see [RULE1] see [RULE2] see [RULE8] see [RULE9] see [RULE20]
      end
      `CMD_READ: begin
        ready_c = run & rcd_zero[cmd_bank] & (wtr_q == 2'h0) & (xsrd_q == 8'h00); // see [RULE3] see [RULE11] see [RULE14]
      end
      `CMD_WRITE: begin
        ready_c = run & rcd_zero[cmd_bank] & (xsnr_q == 7'h00); // see [RULE3] see [RULE13]
      end
      `CMD_PRECHARGE: begin
        ready_c = run & ras_zero[cmd_bank] & (wr_q == 3'h0) & (rtp_q == 3'h0)
                  & (xsnr_q == 7'h00); // see [RULE4] see [RULE6] see [RULE15]
      end
      default: begin
        ready_c = 1'b0;
      end
    endcase
  end

  // per-bank row counters
  genvar b;
  generate
    for (b = 0; b < NBANKS; b = b + 1) begin : g_bank
      reg [2:0] rcd_q;
      reg [4:0] ras_q;
      reg [2:0] rp_q;
      wire hit = (cmd_bank == b);
      // load on the bank's own activate / precharge
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          rcd_q <= 3'h0;
          ras_q <= 5'h00;
          rp_q <= 3'h0;
        end else begin
          if (is_act & hit) begin
            rcd_q <= timing_pri_q[`F_RCD]; // see [RULE3] see [RULE19] see [RULE20]
            ras_q <= timing_pri_q[`F_RAS]; // see [RULE6] see [RULE20]
          end else begin
            if (rcd_q != 3'h0) rcd_q <= rcd_q - 3'h1;
            if (ras_q != 5'h00) ras_q <= ras_q - 5'h01;
          end
          if (is_pre & hit) begin
            rp_q <= timing_pri_q[`F_RP]; // see [RULE2] see [RULE20]
          end else if (rp_q != 3'h0) begin
            rp_q <= rp_q - 3'h1;
          end
        end
      end
      assign rcd_zero[b] = (rcd_q == 3'h0);
      assign ras_zero[b] = (ras_q == 5'h00);
      assign rp_zero[b] = (rp_q == 3'h0);
    end
  endgenerate

  // global down-counters, loaded by their triggering event
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rfc_q <= 7'h00;
      rc_q <= 5'h00;
      rrd_q <= 3'h0;
      wtr_q <= 2'h0;
      wr_q <= 3'h0;
      rtp_q <= 3'h0;
    end else begin
      if (is_rfc) rfc_q <= timing_pri_q[`F_RFC]; // see [RULE1] see [RULE19]
      else if (rfc_q != 7'h00) rfc_q <= rfc_q - 7'h01;
      if (is_act) rc_q <= timing_pri_q[`F_RC]; // see [RULE8]
      else if (rc_q != 5'h00) rc_q <= rc_q - 5'h01;
      if (is_act) rrd_q <= timing_pri_q[`F_RRD]; // see [RULE9]
      else if (rrd_q != 3'h0) rrd_q <= rrd_q - 3'h1;
      if (is_wr) wtr_q <= timing_pri_q[`F_WTR]; // see [RULE11]
      else if (wtr_q != 2'h0) wtr_q <= wtr_q - 2'h1;
      if (write_data_last) wr_q <= timing_pri_q[`F_WR]; // see [RULE4]
      else if (wr_q != 3'h0) wr_q <= wr_q - 3'h1;
      if (is_rd) rtp_q <= timing_sec_q[`F_RTP]; // see [RULE15]
      else if (rtp_q != 3'h0) rtp_q <= rtp_q - 3'h1;
    end
  end

  // clock-enable sequencing for self-refresh entry and exit
  wire cke_may_move = (cke_cnt_q == 5'h00); // see [RULE16]
  wire sr_enter = cke & sr_req & cke_may_move; // see [RULE18]
  wire sr_exit = ~cke & ~sr_req & cke_may_move; // see [RULE18]

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke <= 1'b1;
      cke_cnt_q <= 5'h00;
      xsnr_q <= 7'h00;
      xsrd_q <= 8'h00;
    end else begin
      if (sr_enter | sr_exit) begin
        cke <= ~cke;
        cke_cnt_q <= timing_sec_q[`F_CKE]; // see [RULE16]
      end else if (cke_cnt_q != 5'h00) begin
        cke_cnt_q <= cke_cnt_q - 5'h01;
      end
      if (sr_exit) begin
        xsnr_q <= timing_sec_q[`F_XSNR]; // see [RULE13]
        xsrd_q <= timing_sec_q[`F_XSRD]; // see [RULE14]
      end else begin
        if (xsnr_q != 7'h00) xsnr_q <= xsnr_q - 7'h01;
        if (xsrd_q != 8'h00) xsrd_q <= xsrd_q - 8'h01;
      end
    end
  end

  // register writes and init trigger
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timing_pri_q <= `RST_TIMING_PRI;
      timing_sec_q <= `RST_TIMING_SEC; // see [RULE17]
      bank_cfg_q <= `RST_BANK_CFG;
      ref_ctrl_q <= `RST_REF_CTRL;
      init_start <= 1'b0;
    end else begin
      init_start <= wr_pri & (pri_new[`F_WR] != timing_pri_q[`F_WR]); // see [RULE5]
      if (wr_pri) timing_pri_q <= pri_new;
      if (wr_sec) timing_sec_q <= pwdata & `SEC_MASK;
      if (access_wr & hit_bank) bank_cfg_q <= pwdata;
      if (access_wr & hit_ref) ref_ctrl_q <= pwdata; // see [RULE18]
    end
  end

  // read data captured in the setup phase
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite) begin
      if (hit_status) prdata <= {29'h0000_0000, (|cke_cnt_q), ~cke, cke};
      else if (hit_bank) prdata <= bank_cfg_q;
      else if (hit_ref) prdata <= ref_ctrl_q;
      else if (hit_pri) prdata <= timing_pri_q;
      else if (hit_sec) prdata <= timing_sec_q;
      else prdata <= 32'h0000_0000;
    end
  end

endmodule

/* File: ddr2_command_timing_enforcer_tb.sv */
`timescale 1ns/1ps
`include "ddr2_timing_regs.vh"
module ddr2_command_timing_enforcer_tb;
  reg clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cmd_valid = 0, err;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd, pv = 0, old = 0, sv;
  reg [2:0] cmd_type = 0, cmd_bank = 0;
  wire [31:0] prdata;
  wire pready, pslverr, cmd_ready, wdl, cke, init_start, sra;
  integer failures = 0, tests_run = 0, seed = 93, inits = 0, ie = 0, r, n;
  ddr2_command_timing_enforcer uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_ready(cmd_ready),
    .write_data_last(wdl), .cke(cke), .init_start(init_start), .self_refresh_active(sra));
  ddr2_data_beat_model mem (.clock(clock), .rst_n(rst_n), .cmd_fire(cmd_valid && cmd_ready),
    .cmd_type(cmd_type), .write_data_last(wdl));
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (init_start === 1'b1) inits = inits + 1;
  task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
    end
  endtask
  function [7:0] mx(input [7:0] a, input [7:0] b);
    mx = a > b ? a : b;
  endfunction
  // issue a trigger (7 means self-refresh exit), count cycles the dependent waits
  task gap(input [2:0] t, input [2:0] d, input [2:0] db, input sk, input [7:0] exp);
    begin
      if (t == 3'h7) begin
        apb(1, `OFS_REFRESH_CTRL, 32'h8000_0000);
        repeat (40) @(posedge clock);
        check({cke, sra}, 2'b01, "sr entry");
        apb(1, `OFS_REFRESH_CTRL, 32'h0000_0000);
        @(posedge cke);
      end else begin
        cmd_valid <= 1;
        cmd_type <= t;
        cmd_bank <= 1;
        @(posedge clock);
        while (cmd_ready !== 1'b1) @(posedge clock);
      end
      if (sk) begin
        cmd_valid <= 0;
        @(posedge clock);
      end
      cmd_valid <= 1;
      cmd_type <= d;
      cmd_bank <= db;
      n = 0;
      @(posedge clock);
      while (cmd_ready !== 1'b1 && n < 300) begin
        n = n + 1;
        @(posedge clock);
      end
      cmd_valid <= 0;
      check(n, exp, "gap");
      $display("gap test %0d to %0d done", t, d);
      repeat (300) @(posedge clock);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (50000) @(posedge clock);
    failures = failures + 1;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    apb(0, `OFS_TIMING_SEC, 0);
    check(rd & 32'hFE7F_FFFF, `RST_TIMING_SEC, "sec reset");
    apb(0, 12'h020, 0);
    check(rd, 32'h0000_0000, "unmapped");
    check({31'h0000_0000, err}, 32'h0000_0001, "slverr");
    for (r = 0; r < 3; r = r + 1) begin
      pv = $random(seed) & `PRI_MASK; // any rrd value is a legal software result
      pv[15:11] = pv[21:19] + pv[14:12];
      sv = $random(seed) & 32'h007F_FFFF;
      ie = ie + (pv[18:16] != old[18:16]);
      apb(1, `OFS_BANK_CONFIG, 0);
      apb(1, `OFS_TIMING_PRI, ~pv);
      apb(0, `OFS_TIMING_PRI, 0);
      check(rd, old, "locked");
      apb(1, `OFS_BANK_CONFIG, 32'h0000_8000);
      apb(1, `OFS_TIMING_PRI, pv);
      apb(1, `OFS_TIMING_SEC, sv);
      apb(0, `OFS_TIMING_PRI, 0);
      check(rd, pv, "primary");
      check(inits, ie, "init");
      old = pv;
      gap(`CMD_ACTIVATE, `CMD_READ, 1, 0, pv[21:19]);
      gap(`CMD_ACTIVATE, `CMD_PRECHARGE, 1, 0, pv[15:11]);
      gap(`CMD_ACTIVATE, `CMD_ACTIVATE, 1, 0, mx(pv[10:6], pv[5:3]));
      gap(`CMD_ACTIVATE, `CMD_ACTIVATE, 2, 0, mx(pv[10:6], pv[5:3]));
      gap(`CMD_PRECHARGE, `CMD_ACTIVATE, 1, 0, pv[24:22]);
      gap(`CMD_REFRESH, `CMD_ACTIVATE, 1, 0, pv[31:25]);
      gap(`CMD_WRITE, `CMD_READ, 1, 0, pv[1:0]);
      gap(`CMD_READ, `CMD_PRECHARGE, 1, 0, sv[7:5]);
      gap(`CMD_WRITE, `CMD_PRECHARGE, 1, 1, pv[18:16]);
      gap(3'h7, `CMD_READ, 1, 0, sv[15:8]);
      gap(3'h7, `CMD_ACTIVATE, 1, 0, sv[22:16]);
    end
    close_out;
  end
endmodule
bind ddr2_command_timing_enforcer ddr2_cte_monitor #(.BANK_W(BANK_W)) mon (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
  .cmd_ready(cmd_ready), .write_data_last(write_data_last), .cke(cke), .init_start(init_start),
  .self_refresh_active(self_refresh_active));

/* File: ddr2_cte_monitor.sv */
`timescale 1ns/1ps
`include "ddr2_timing_regs.vh"
module ddr2_cte_monitor #(
  parameter BANK_W = 3
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // commands
  input wire cmd_valid,
  input wire [2:0] cmd_type,
  input wire [BANK_W-1:0] cmd_bank,
  input wire cmd_ready,
  input wire write_data_last,
  // memory status
  input wire cke,
  input wire init_start,
  input wire self_refresh_active
);
  reg [31:0] pri_q;
  reg unl_q;
  reg cke_d_q;
  reg moved_q;
  reg [5:0] hold_q;
  reg [4:0] ckef_q;
  wire wr_en = psel && penable && pwrite;
  wire pri_wr = wr_en && paddr == `OFS_TIMING_PRI && unl_q;
  wire go = cmd_valid && cmd_ready;
  // shadow of primary timing word and unlock bit
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pri_q <= 32'h0000_0000;
      unl_q <= 1'b0;
    end else begin
      if (pri_wr) pri_q <= pwdata;
      if (wr_en && paddr == `OFS_BANK_CONFIG) unl_q <= pwdata[`BIT_UNLOCK];
    end
  end
  // cycles cke has stood since its last move, and the programmed hold
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_d_q <= 1'b1;
      moved_q <= 1'b0;
      hold_q <= 6'h00;
      ckef_q <= 5'h00;
    end else begin
      cke_d_q <= cke;
      if (cke != cke_d_q) begin
        hold_q <= 6'h00;
        moved_q <= 1'b1;
      end else if (hold_q != 6'h3F) begin
        hold_q <= hold_q + 6'h01;
      end
      if (wr_en && paddr == `OFS_TIMING_SEC && unl_q) ckef_q <= pwdata[4:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_const: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no slave error");
  a_init_cause: assert property (pri_wr && pwdata[18:16] != pri_q[18:16] |=> init_start)
    else $error("init not started");
  a_init_single: assert property (init_start |=> !init_start) else $error("init pulse too long");
  a_sr_mirror: assert property (self_refresh_active == !cke) else $error("self refresh flag wrong");
  a_sr_block: assert property (!cke |-> !cmd_ready) else $error("command in self refresh");
  a_bad_code: assert property (cmd_type > 3'h5 |-> !cmd_ready) else $error("bad code ready");
  a_cke_hold: assert property ($changed(cke) && moved_q |-> hold_q >= {1'b0, ckef_q})
    else $error("cke moved too soon");
  a_act_read: assert property (go && cmd_type == `CMD_ACTIVATE && pri_q[21:19] != 0
    |=> !(cmd_ready && cmd_type == `CMD_READ && cmd_bank == $past(cmd_bank))) else $error("read too early");
  a_refresh_act: assert property (go && cmd_type == `CMD_REFRESH && pri_q[31:25] != 0
    |=> !(cmd_ready && cmd_type == `CMD_ACTIVATE)) else $error("activate too early");
  // main scenarios reached
  c_act: cover property (go && cmd_type == `CMD_ACTIVATE);
  c_init: cover property (init_start);
  c_sr: cover property ($fell(cke));
endmodule

/* File: ddr2_data_beat_model.sv */
`timescale 1ns/1ps
`include "ddr2_timing_regs.vh"
module ddr2_data_beat_model (
  // issued command
  input wire clock,
  input wire rst_n,
  input wire cmd_fire,
  input wire [2:0] cmd_type,
  // last write data beat
  output reg write_data_last
);
  // final beat lands one cycle after each issued write
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_data_last <= 1'b0;
    end else begin
      write_data_last <= cmd_fire && cmd_type == `CMD_WRITE;
    end
  end
endmodule

/* File: ddr2_timing_regs.vh */
// Behaviour
// [RULE1] refresh/mode-load to refresh/activate spacing enforced
// [RULE2] precharge to refresh/activate spacing enforced
// [RULE3] activate to read/write spacing enforced
// [RULE4] last write data to precharge recovery
// [RULE5] changed write-recovery field starts initialisation
// [RULE6] activate to precharge row-active time
// [RULE7] software keeps active time >= activate-to-column
// [RULE8] activate to activate spacing enforced
// [RULE9] activate spacing across different banks
// [RULE10] software uses special formula for 8 banks
// [RULE11] last write to read spacing enforced
// [RULE12] timing writes only while unlock bit set
// [RULE13] self-refresh exit to non-read commands wait
// [RULE14] self-refresh exit to read wait
// [RULE15] last read to precharge spacing
// [RULE16] clock-enable held stable between transitions
// [RULE17] reserved secondary bits undefined after reset
// [RULE18] refresh control bit 31 enters/exits self-refresh
// [RULE19] one down-counter per constraint gates commands
// [RULE20] row constraints tracked per bank
`ifndef DDR2_TIMING_REGS_VH
`define DDR2_TIMING_REGS_VH

// register byte offsets
`define OFS_STATUS       12'h000
`define OFS_BANK_CONFIG  12'h004
`define OFS_REFRESH_CTRL 12'h008
`define OFS_TIMING_PRI   12'h00C
`define OFS_TIMING_SEC   12'h010

// bank config / refresh control bits
`define BIT_UNLOCK   15
`define BIT_SELF_REF 31

// primary timing fields
`define F_RFC 31:25
`define F_RP  24:22
`define F_RCD 21:19
`define F_WR  18:16
`define F_RAS 15:11
`define F_RC  10:6
`define F_RRD 5:3
`define F_WTR 1:0
// primary writable mask (bit 2 reserved)
`define PRI_MASK 32'hFFFF_FFFB

// secondary timing fields
`define F_XSNR 22:16
`define F_XSRD 15:8
`define F_RTP  7:5
`define F_CKE  4:0
// secondary writable mask (31-25 reserved zero)
`define SEC_MASK 32'h01FF_FFFF

// reset values
`define RST_TIMING_PRI 32'h0000_0000
`define RST_TIMING_SEC 32'h0010_02A0
`define RST_BANK_CFG   32'h0000_0000
`define RST_REF_CTRL   32'h0000_0000

// command codes
`define CMD_REFRESH   3'h0
`define CMD_MODE_LOAD 3'h1
`define CMD_ACTIVATE  3'h2
`define CMD_READ      3'h3
`define CMD_WRITE     3'h4
`define CMD_PRECHARGE 3'h5

`endif
